// >>> src/rail_monitor_dev.sv
/*
  device end: rail overvoltage/undervoltage deglitch, flags, regulator
  switch-off, reset and safety reactions, and static scaling of the core buck.
  assumes comparator results arrive asynchronously; monitor enable, init
  phase and one-time-programmed settings come from logic on clk_in.
*/
`timescale 1ns/1ps

// Behaviour
// - supervise ov/uv on all seven rails
// - own regulator off while overvoltage persists
// - monitoring and flags only when enabled
// - core ov reaction field, default both
// - core uv reaction field, default safety only
// - reaction fields writable only in init
// - ov threshold 2.5 to 10 percent
// - uv threshold -2.5 to -10 percent
// - ov 25/45us, uv 5/15/25/40us deglitch
// - controller scales only during init phase
// - 6-bit offset, 6.25 mV per step
// - controller writes complement of the offset
// - transition starts after matching complement
// - mismatched complement keeps previous voltage
// - clamp limits steps, zero disables scaling
// - range setting: negative only or both
// - sign bit chooses direction when full range
// - thresholds move with validated scaling
// - controller splits large changes into steps
module rail_monitor_dev
  import rail_monitor_pkg::*;
#(
  parameter int                     NUM_RAILS = `NUM_RAILS,
  parameter logic [`NUM_RAILS-1:0]  OWN_MASK  = `OWN_REG_MASK
) (
  input  wire logic                  clk_in,
  input  wire logic                  rst_b_in,
  rail_monitor_if.device             link,
  input  wire logic [NUM_RAILS-1:0]  ov_cmp_in,
  input  wire logic [NUM_RAILS-1:0]  uv_cmp_in,
  input  wire logic                  failsafe_monitor_enable_in,
  input  wire logic                  safety_init_phase_in,
  input  wire logic [NUM_RAILS-1:0]  ov_deglitch_sel_in,
  input  wire logic [2*NUM_RAILS-1:0] uv_deglitch_sel_in,
  input  wire logic [3:0]            core_ov_threshold_code_in,
  input  wire logic [3:0]            core_uv_threshold_code_in,
  input  wire logic [`OFS_W-1:0]     scaling_step_clamp_in,
  input  wire logic                  scaling_range_select_in,
  output logic [NUM_RAILS-1:0]       reg_off_out,
  output logic                       reset_output_n_out,
  output logic                       safety_output_n_out,
  output logic [`OFS_W-1:0]          scaling_offset_out,
  output logic                       scaling_offset_sign_out,
  output logic                       scaling_start_out,
  output logic [`THR_W-1:0]          core_ov_thr_half_pct_out,
  output logic [`THR_W-1:0]          core_uv_thr_half_pct_out
);

  localparam logic [`DGL_CNT_W-1:0] OV_SHORT = `DGL_CNT_W'(`US_TO_CYC(`OV_DGL_SHORT_US));
  localparam logic [`DGL_CNT_W-1:0] OV_LONG  = `DGL_CNT_W'(`US_TO_CYC(`OV_DGL_LONG_US));
  localparam logic [`DGL_CNT_W-1:0] UV_D0    = `DGL_CNT_W'(`US_TO_CYC(`UV_DGL_0_US));
  localparam logic [`DGL_CNT_W-1:0] UV_D1    = `DGL_CNT_W'(`US_TO_CYC(`UV_DGL_1_US));
  localparam logic [`DGL_CNT_W-1:0] UV_D2    = `DGL_CNT_W'(`US_TO_CYC(`UV_DGL_2_US));
  localparam logic [`DGL_CNT_W-1:0] UV_D3    = `DGL_CNT_W'(`US_TO_CYC(`UV_DGL_3_US));

  // ==========================================================
  // comparator synchronisers
  // ==========================================================
  logic [NUM_RAILS-1:0] ov_meta_r;
  logic [NUM_RAILS-1:0] ov_sync_r;
  logic [NUM_RAILS-1:0] uv_meta_r;
  logic [NUM_RAILS-1:0] uv_sync_r;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ov_meta_r <= '0;
      ov_sync_r <= '0;
      uv_meta_r <= '0;
      uv_sync_r <= '0;
    end else begin
      ov_meta_r <= ov_cmp_in;
      ov_sync_r <= ov_meta_r;
      uv_meta_r <= uv_cmp_in;
      uv_sync_r <= uv_meta_r;
    end
  end

  // ==========================================================
  // deglitch per rail
  // ==========================================================
  logic [NUM_RAILS-1:0] ov_qual;
  logic [NUM_RAILS-1:0] uv_qual;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_RAILS; gi++) begin : g_rail
      logic [`DGL_CNT_W-1:0] ov_cnt_r;
      logic [`DGL_CNT_W-1:0] uv_cnt_r;
      logic [`DGL_CNT_W-1:0] ov_lim;
      logic [`DGL_CNT_W-1:0] uv_lim;
      assign ov_lim = ov_deglitch_sel_in[gi] ? OV_LONG : OV_SHORT;
      always_comb begin
        case (uv_deglitch_sel_in[2*gi +: 2])
          2'h0:    uv_lim = UV_D0;
          2'h1:    uv_lim = UV_D1;
          2'h2:    uv_lim = UV_D2;
          default: uv_lim = UV_D3;
        endcase
      end
      always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          ov_cnt_r <= '0;
          uv_cnt_r <= '0;
        end else begin
          if (!(failsafe_monitor_enable_in && ov_sync_r[gi]))
            ov_cnt_r <= '0;
          else if (ov_cnt_r != ov_lim)
            ov_cnt_r <= ov_cnt_r + 1'b1;
          if (!(failsafe_monitor_enable_in && uv_sync_r[gi]))
            uv_cnt_r <= '0;
          else if (uv_cnt_r != uv_lim)
            uv_cnt_r <= uv_cnt_r + 1'b1;
        end
      end
      assign ov_qual[gi] = failsafe_monitor_enable_in && ov_sync_r[gi] && (ov_cnt_r == ov_lim);
      assign uv_qual[gi] = failsafe_monitor_enable_in && uv_sync_r[gi] && (uv_cnt_r == uv_lim);
    end
  endgenerate

  // ==========================================================
  // sticky flags, set wins over clear
  // ==========================================================
  logic                 clear_cmd;
  logic [NUM_RAILS-1:0] ov_flags_r;
  logic [NUM_RAILS-1:0] uv_flags_r;

  assign clear_cmd = link.cmd_valid && (link.cmd_sel == CMD_CLEAR);

  // flags set only from qualified faults
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ov_flags_r <= '0;
      uv_flags_r <= '0;
    end else begin
      ov_flags_r <= (clear_cmd ? '0 : ov_flags_r) | ov_qual;
      uv_flags_r <= (clear_cmd ? '0 : uv_flags_r) | uv_qual;
    end
  end

  assign link.ov_flags   = ov_flags_r;
  assign link.uv_flags   = uv_flags_r;
  assign link.init_phase = safety_init_phase_in;

  // ==========================================================
  // regulator switch-off
  // ==========================================================
  // off only for own regulators, released when fault clears
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in)
      reg_off_out <= '0;
    else
      reg_off_out <= ov_qual & OWN_MASK;
  end

  // ==========================================================
  // core reaction fields and outputs
  // ==========================================================
  logic [1:0] core_ov_reaction_sel_r;
  logic [1:0] core_uv_reaction_sel_r;
  logic       react_safe;
  logic       react_reset;

  // writes outside init phase are ignored
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      core_ov_reaction_sel_r <= `REACT_OV_RESET;
      core_uv_reaction_sel_r <= `REACT_UV_RESET;
    end else if (link.cmd_valid && link.cmd_sel == CMD_REACTION && safety_init_phase_in) begin
      core_ov_reaction_sel_r <= link.cmd_data[`REACT_OV_LSB +: 2];
      core_uv_reaction_sel_r <= link.cmd_data[`REACT_UV_LSB +: 2];
    end
  end

  // decode: 01 safety only, 1x both
  always_comb begin
    react_safe  = 1'b0;
    react_reset = 1'b0;
    if (ov_qual[`RAIL_CORE] && core_ov_reaction_sel_r != `REACT_NONE) begin
      react_safe  = 1'b1;
      react_reset = (core_ov_reaction_sel_r != `REACT_SAFE_ONLY);
    end
    if (uv_qual[`RAIL_CORE] && core_uv_reaction_sel_r != `REACT_NONE) begin
      react_safe  = 1'b1;
      react_reset = react_reset || (core_uv_reaction_sel_r != `REACT_SAFE_ONLY);
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      safety_output_n_out <= 1'b1;
      reset_output_n_out  <= 1'b1;
    end else begin
      safety_output_n_out <= !react_safe;
      reset_output_n_out  <= !react_reset;
    end
  end

  // ==========================================================
  // static scaling
  // ==========================================================
  logic [`OFS_W-1:0] req_ofs_r;
  logic              req_sign_r;
  logic [`OFS_W-1:0] clamped_ofs;
  logic              cmp_cmd;
  logic              cmp_good;

  // a later offset write simply replaces the pending one
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      req_ofs_r  <= `OFS_RESET;
      req_sign_r <= 1'b0;
    end else if (link.cmd_valid && link.cmd_sel == CMD_OFFSET && safety_init_phase_in) begin
      req_ofs_r  <= link.cmd_data[`OFS_W-1:0];
      req_sign_r <= link.cmd_data[`OFS_SIGN_BIT];
    end
  end

  // clamp code c allows c steps, so top code is c
  assign clamped_ofs = (req_ofs_r > scaling_step_clamp_in) ? scaling_step_clamp_in : req_ofs_r;
  assign cmp_cmd     = link.cmd_valid && link.cmd_sel == CMD_COMPLEMENT && safety_init_phase_in;
  // complement must be the exact inverse
  assign cmp_good    = (link.cmd_data[`OFS_W-1:0] == ~req_ofs_r);

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      scaling_offset_out      <= `OFS_RESET;
      scaling_offset_sign_out <= 1'b0;
      scaling_start_out       <= 1'b0;
      link.scaling_done       <= 1'b0;
      link.scaling_reject     <= 1'b0;
    end else begin
      scaling_start_out   <= cmp_cmd && cmp_good;
      link.scaling_done   <= cmp_cmd && cmp_good;
      link.scaling_reject <= cmp_cmd && !cmp_good;
      if (cmp_cmd && cmp_good) begin
        scaling_offset_out      <= clamped_ofs;
        // negative only unless full range is selected
        scaling_offset_sign_out <= scaling_range_select_in && req_sign_r;
      end
    end
  end

  // ==========================================================
  // core thresholds
  // ==========================================================
  // thresholds are relative to the live target, which moves
  // in the same cycle as the scaling start
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      core_ov_thr_half_pct_out <= `THR_BASE_HALF_PCT;
      core_uv_thr_half_pct_out <= `THR_BASE_HALF_PCT;
    end else begin
      core_ov_thr_half_pct_out <= `THR_BASE_HALF_PCT + `THR_W'(core_ov_threshold_code_in);
      core_uv_thr_half_pct_out <= `THR_BASE_HALF_PCT + `THR_W'(core_uv_threshold_code_in);
    end
  end
endmodule : rail_monitor_dev

// >>> src/rail_monitor_host.sv
/*
  controller end: programs reaction fields, walks a scaling target in small
  offset/complement steps, and clears fault flags.
  assumes user requests are one-cycle pulses on clk_in.
*/
`timescale 1ns/1ps
module rail_monitor_host
  import rail_monitor_pkg::*;
#(
  parameter logic [`OFS_W-1:0]      MAX_STEP   = 6'h04,
  parameter logic [`DGL_CNT_W-1:0]  SETTLE_CYC = `DGL_CNT_W'(`US_TO_CYC(`OV_DGL_LONG_US))
) (
  input  wire logic                 clk_in,
  input  wire logic                 rst_b_in,
  rail_monitor_if.host              link,
  input  wire logic                 reaction_req_in,
  input  wire logic [3:0]           reaction_val_in,
  input  wire logic                 scale_req_in,
  input  wire logic [`OFS_W-1:0]    scale_target_in,
  input  wire logic                 scale_sign_in,
  input  wire logic                 clear_req_in,
  output logic                      busy_out,
  output logic                      scale_fail_out
);

  host_state_t           state_r;
  logic [`OFS_W-1:0]     cur_r;
  logic [`OFS_W-1:0]     tgt_r;
  logic                  sign_r;
  logic [`OFS_W-1:0]     next_ofs;
  logic [`DGL_CNT_W-1:0] wait_r;

  // move at most MAX_STEP codes per write pair
  always_comb begin
    if (tgt_r > cur_r)
      next_ofs = (tgt_r - cur_r > MAX_STEP) ? cur_r + MAX_STEP : tgt_r;
    else
      next_ofs = (cur_r - tgt_r > MAX_STEP) ? cur_r - MAX_STEP : tgt_r;
  end

  // ==========================================================
  // sequencer
  // ==========================================================
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_r        <= H_IDLE;
      cur_r          <= `OFS_RESET;
      tgt_r          <= `OFS_RESET;
      sign_r         <= 1'b0;
      wait_r         <= '0;
      busy_out       <= 1'b0;
      scale_fail_out <= 1'b0;
      link.cmd_valid <= 1'b0;
      link.cmd_sel   <= CMD_CLEAR;
      link.cmd_data  <= 8'h00;
    end else begin
      link.cmd_valid <= 1'b0;
      case (state_r)
        H_IDLE: begin
          busy_out <= 1'b0;
          // configuration only inside the init phase
          if (reaction_req_in && link.init_phase) begin
            link.cmd_valid <= 1'b1;
            link.cmd_sel   <= CMD_REACTION;
            link.cmd_data  <= {4'h0, reaction_val_in};
          end else if (scale_req_in && link.init_phase) begin
            tgt_r          <= scale_target_in;
            sign_r         <= scale_sign_in;
            scale_fail_out <= 1'b0;
            busy_out       <= 1'b1;
            state_r        <= H_WR_OFS;
          end else if (clear_req_in) begin
            link.cmd_valid <= 1'b1;
            link.cmd_sel   <= CMD_CLEAR;
            link.cmd_data  <= 8'h00;
          end
        end
        H_WR_OFS: begin
          if (cur_r == tgt_r || !link.init_phase) begin
            state_r <= H_IDLE;
          end else begin
            link.cmd_valid <= 1'b1;
            link.cmd_sel   <= CMD_OFFSET;
            link.cmd_data  <= {1'b0, sign_r, next_ofs};
            cur_r          <= next_ofs;
            state_r        <= H_WR_CMP;
          end
        end
        H_WR_CMP: begin
          // complement of the offset just written
          link.cmd_valid <= 1'b1;
          link.cmd_sel   <= CMD_COMPLEMENT;
          link.cmd_data  <= {2'h0, ~cur_r};
          wait_r         <= SETTLE_CYC;
          state_r        <= H_SETTLE;
        end
        H_SETTLE: begin
          if (link.scaling_reject) begin
            scale_fail_out <= 1'b1;
            state_r        <= H_IDLE;
          end else if (wait_r == '0) begin
            state_r <= H_WR_OFS;
          end else begin
            wait_r <= wait_r - 1'b1;
          end
        end
        default: state_r <= H_IDLE;
      endcase
    end
  end
endmodule : rail_monitor_host

// >>> src/rail_monitor_if.sv
/*
  link between the controller and the monitor: a one-cycle command strobe
  with selector and data, and status returned by the device.
  assumes both ends share clk_in.
*/
`timescale 1ns/1ps
interface rail_monitor_if
  import rail_monitor_pkg::*;
();
  logic                  cmd_valid;
  cmd_sel_t              cmd_sel;
  logic [7:0]            cmd_data;
  logic                  init_phase;
  logic [`NUM_RAILS-1:0] ov_flags;
  logic [`NUM_RAILS-1:0] uv_flags;
  logic                  scaling_done;
  logic                  scaling_reject;

  modport device (input cmd_valid, cmd_sel, cmd_data,
                  output init_phase, ov_flags, uv_flags, scaling_done, scaling_reject);
  modport host   (output cmd_valid, cmd_sel, cmd_data,
                  input init_phase, ov_flags, uv_flags, scaling_done, scaling_reject);
endinterface : rail_monitor_if

// >>> src/rail_monitor_params.svh
/*
  constants of the rail monitor and static scaling block: timing, field
  positions, reset values and command field layouts.
  assumes a 20 MHz clock and inclusion by both ends and the package.
*/
`ifndef RAIL_MONITOR_PARAMS_SVH
`define RAIL_MONITOR_PARAMS_SVH

// ==========================================================
// clock and deglitch times
// ==========================================================
`define CLK_PERIOD_NS     50
`define NS_PER_US         1000
`define OV_DGL_SHORT_US   25
`define OV_DGL_LONG_US    45
`define UV_DGL_0_US       5
`define UV_DGL_1_US       15
`define UV_DGL_2_US       25
`define UV_DGL_3_US       40
// least time, rounded up to whole cycles
`define US_TO_CYC(us)     (((us) * `NS_PER_US + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DGL_CNT_W         10

// ==========================================================
// rail indices and widths
// ==========================================================
`define NUM_RAILS         7
`define RAIL_CORE         0
`define OWN_REG_MASK      7'h07

// ==========================================================
// reaction field layout and reset values
// ==========================================================
`define REACT_OV_LSB      0
`define REACT_UV_LSB      2
`define REACT_OV_RESET    2'h3
`define REACT_UV_RESET    2'h1
`define REACT_NONE        2'h0
`define REACT_SAFE_ONLY   2'h1

// ==========================================================
// scaling field layout
// ==========================================================
`define OFS_W             6
`define OFS_RESET         6'h00
`define OFS_SIGN_BIT      6

// threshold code to half-percent units: 2.5 % is 5 half-percents
`define THR_BASE_HALF_PCT 5'h05
`define THR_W             5

`endif

// >>> src/rail_monitor_pkg.sv
/*
  types shared by both ends of the rail monitor link.
  assumes rail_monitor_params.svh is on the include path.
*/
package rail_monitor_pkg;
  `include "rail_monitor_params.svh"

  typedef enum logic [1:0] {
    CMD_REACTION   = 2'h0,
    CMD_OFFSET     = 2'h1,
    CMD_COMPLEMENT = 2'h2,
    CMD_CLEAR      = 2'h3
  } cmd_sel_t;

  typedef enum logic [1:0] {
    H_IDLE    = 2'h0,
    H_WR_OFS  = 2'h1,
    H_WR_CMP  = 2'h3,
    H_SETTLE  = 2'h2
  } host_state_t;
endpackage : rail_monitor_pkg

// >>> test/rail_monitor_checker.sv
/*
  concurrent checks on the command link between controller and device.
  assumes one clock domain; instantiated beside the link, no bind.
*/
`timescale 1ns/1ps
`include "rail_monitor_params.svh"
module rail_monitor_checker
  import rail_monitor_pkg::*;
(
  input  wire logic                  clk_in,
  input  wire logic                  rst_b_in,
  input  wire logic                  cmd_valid,
  input  wire cmd_sel_t              cmd_sel,
  input  wire logic [7:0]            cmd_data,
  input  wire logic                  init_phase,
  input  wire logic [`NUM_RAILS-1:0] ov_flags,
  input  wire logic [`NUM_RAILS-1:0] uv_flags,
  input  wire logic                  scaling_done,
  input  wire logic                  scaling_reject
);
  logic [`OFS_W-1:0] ofs_last_r;

  // complement is judged against the last offset the device took
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ofs_last_r <= `OFS_RESET;
    end else if (cmd_valid && cmd_sel == CMD_OFFSET && init_phase) begin
      ofs_last_r <= cmd_data[`OFS_W-1:0];
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);

  // ==========================================================
  // command sequences
  // ==========================================================
  sequence cmp_sent;
    cmd_valid && cmd_sel == CMD_COMPLEMENT;
  endsequence
  sequence cmp_good;
    cmp_sent ##0 (init_phase && cmd_data[`OFS_W-1:0] == ~ofs_last_r);
  endsequence
  sequence link_quiet;
    !cmd_valid [*4];
  endsequence

  chk_done_after_good: assert property (cmp_good |=> scaling_done && !scaling_reject)
    else $error("no scaling_done after matching complement");
  chk_done_has_cause: assert property (scaling_done |-> $past(cmd_valid) && $past(cmd_sel) == CMD_COMPLEMENT)
    else $error("scaling_done without a complement");
  chk_done_one_cycle: assert property (scaling_done |=> !scaling_done)
    else $error("scaling_done longer than one cycle");
  chk_out_of_init: assert property (cmd_valid && !init_phase |=> !scaling_done && !scaling_reject)
    else $error("answer to a command outside init");
  chk_ov_sticky: assert property (|($past(ov_flags) & ~ov_flags) |-> $past(cmd_valid && cmd_sel == CMD_CLEAR))
    else $error("ov flag fell without clear");
  chk_uv_sticky: assert property (|($past(uv_flags) & ~uv_flags) |-> $past(cmd_valid && cmd_sel == CMD_CLEAR))
    else $error("uv flag fell without clear");
  chk_scale_in_init: assert property (cmd_valid && cmd_sel inside {CMD_OFFSET, CMD_COMPLEMENT} |-> init_phase)
    else $error("scaling command outside init");
  chk_react_in_init: assert property (cmd_valid && cmd_sel == CMD_REACTION |-> init_phase)
    else $error("reaction write outside init");
  chk_cmp_matches: assert property (cmp_sent |-> cmd_data[`OFS_W-1:0] == ~ofs_last_r)
    else $error("complement does not match offset");
  chk_settle_gap: assert property (cmp_sent |=> link_quiet)
    else $error("command inside settle time");
endmodule : rail_monitor_checker

// >>> test/rail_monitor_static_scaling_tb_top.sv
/*
  testbench: controller and device joined on one link, plus a second device
  driven by the bench to send refused and mismatched commands.
  assumes package, header and interface are compiled first.
*/
`timescale 1ns/1ps
module rail_monitor_static_scaling_tb_top
  import rail_monitor_pkg::*;
;
  logic        clk_in = 1'b0;
  logic        rst_b_in, fs_en, init, range_sel, react_req, scale_req, scale_sign, clear_req;
  logic [6:0]  ov_cmp, uv_cmp, ov_dgl, reg_off_a;
  logic [13:0] uv_dgl;
  logic [5:0]  clamp, target, ofs_a, ofs_b;
  logic [4:0]  thr_ov, thr_uv;
  logic [3:0]  react_val;
  logic        rst_n_a, safe_n_a, rst_n_b, safe_n_b, sign_a, sign_b, start_b, busy, fail;
  logic [2:0]  seen;
  int          bad_count = 0;
  int          checked = 0;
  int          n;
  // deglitch times in 50 ns cycles: ov 25/45 us, uv 5/15/25/40 us
  int          lim_tbl [8] = '{500, 900, 500, 900, 100, 300, 500, 800};
  logic [5:0]  clamp_tbl [4] = '{6'h00, 6'h01, 6'h03, 6'h3F};

  rail_monitor_if link_a ();
  rail_monitor_if link_b ();

  always #25 clk_in = ~clk_in;

  rail_monitor_dev rail_monitor_dev_i (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .link(link_a), .ov_cmp_in(ov_cmp), .uv_cmp_in(uv_cmp),
    .failsafe_monitor_enable_in(fs_en), .safety_init_phase_in(init), .ov_deglitch_sel_in(ov_dgl),
    .uv_deglitch_sel_in(uv_dgl), .core_ov_threshold_code_in(4'hF), .core_uv_threshold_code_in(4'h3),
    .scaling_step_clamp_in(clamp), .scaling_range_select_in(range_sel), .reg_off_out(reg_off_a),
    .reset_output_n_out(rst_n_a), .safety_output_n_out(safe_n_a), .scaling_offset_out(ofs_a),
    .scaling_offset_sign_out(sign_a), .scaling_start_out(), .core_ov_thr_half_pct_out(thr_ov),
    .core_uv_thr_half_pct_out(thr_uv));
  // second device: the bench plays a faulty controller here
  rail_monitor_dev rail_monitor_dev_b_i (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .link(link_b), .ov_cmp_in(ov_cmp), .uv_cmp_in(uv_cmp),
    .failsafe_monitor_enable_in(fs_en), .safety_init_phase_in(init), .ov_deglitch_sel_in(ov_dgl),
    .uv_deglitch_sel_in(uv_dgl), .core_ov_threshold_code_in(4'hF), .core_uv_threshold_code_in(4'h3),
    .scaling_step_clamp_in(clamp), .scaling_range_select_in(range_sel), .reg_off_out(),
    .reset_output_n_out(rst_n_b), .safety_output_n_out(safe_n_b), .scaling_offset_out(ofs_b),
    .scaling_offset_sign_out(sign_b), .scaling_start_out(start_b), .core_ov_thr_half_pct_out(),
    .core_uv_thr_half_pct_out());
  rail_monitor_host #(.SETTLE_CYC(10'h008)) rail_monitor_host_i (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .link(link_a), .reaction_req_in(react_req),
    .reaction_val_in(react_val), .scale_req_in(scale_req), .scale_target_in(target),
    .scale_sign_in(scale_sign), .clear_req_in(clear_req), .busy_out(busy), .scale_fail_out(fail));
  rail_monitor_checker rail_monitor_checker_i (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .cmd_valid(link_a.cmd_valid), .cmd_sel(link_a.cmd_sel),
    .cmd_data(link_a.cmd_data), .init_phase(link_a.init_phase), .ov_flags(link_a.ov_flags),
    .uv_flags(link_a.uv_flags), .scaling_done(link_a.scaling_done), .scaling_reject(link_a.scaling_reject));

  // ==========================================================
  // tasks
  // ==========================================================
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk

  task automatic wait_cyc(input int c);
    repeat (c) @(negedge clk_in);
  endtask : wait_cyc

  // one-cycle request to the controller, then wait until it is idle
  task automatic host(input logic [2:0] req);
    int w;
    w = 0;
    {clear_req, scale_req, react_req} = req;
    @(negedge clk_in);
    {clear_req, scale_req, react_req} = 3'h0;
    while (busy !== 1'b0 && w < 500) begin
      @(negedge clk_in);
      w++;
    end
    if (w == 500) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, w, 0);
      end_of_test();
    end
  endtask : host

  // valid is held between back-to-back commands; data is scrambled on release
  task automatic send_b(input cmd_sel_t s, input logic [7:0] d);
    link_b.cmd_sel = s;
    link_b.cmd_data = d;
    link_b.cmd_valid = 1'b1;
    @(negedge clk_in);
  endtask : send_b

  task automatic drop_b();
    link_b.cmd_valid = 1'b0;
    link_b.cmd_data = ~link_b.cmd_data;
  endtask : drop_b

  task automatic scale_b(input logic [7:0] ofs, input logic [5:0] cmp);
    send_b(CMD_OFFSET, ofs);
    send_b(CMD_COMPLEMENT, {2'b00, cmp});
    drop_b();
    seen = 3'h0;
    repeat (3) begin
      seen = seen | {link_b.scaling_done, link_b.scaling_reject, start_b};
      @(negedge clk_in);
    end
  endtask : scale_b

  // ==========================================================
  // main sequence
  // ==========================================================
  initial begin
    {rst_b_in, fs_en, init, range_sel, react_req, scale_req, scale_sign, clear_req} = 8'h00;
    {ov_cmp, uv_cmp, ov_dgl} = 21'h000000;
    uv_dgl = 14'h0000;
    {clamp, target, react_val} = 16'hFC00;
    link_b.cmd_sel = CMD_CLEAR;
    {link_b.cmd_valid, link_b.cmd_data} = 9'h000;
    wait_cyc(8);
    rst_b_in = 1'b1;
    @(negedge clk_in);
    chk({rst_n_a, safe_n_a, rst_n_b, safe_n_b}, 16'h000F);
    chk({thr_ov, thr_uv}, 16'h0288);
    chk({sign_a, ofs_a, sign_b, ofs_b}, 16'h0000);
    $display("test reset values done");
    send_b(CMD_REACTION, 8'h00);
    drop_b();
    @(negedge clk_in);
    scale_b(8'h41, 6'h3E);
    chk({seen, sign_b, ofs_b}, 16'h0000);
    ov_cmp = 7'h15;
    wait_cyc(600);
    chk({reg_off_a, link_a.ov_flags}, 16'h0000);
    fs_en = 1'b1;
    wait_cyc(520);
    chk({reg_off_a, link_a.ov_flags}, 16'h0295);
    chk({rst_n_a, safe_n_a, rst_n_b, safe_n_b}, 16'h0000);
    ov_cmp = 7'h00;
    wait_cyc(5);
    chk({reg_off_a, link_a.ov_flags}, 16'h0015);
    host(3'h4);
    wait_cyc(3);
    chk({9'h000, link_a.ov_flags}, 16'h0000);
    $display("test monitor enable and switch-off done");
    init = 1'b1;
    range_sel = 1'b1;
    {target, scale_sign} = {6'h0A, 1'b1};
    host(3'h2);
    chk({fail, sign_a, ofs_a}, 16'h004A);
    chk({thr_ov, thr_uv}, 16'h0288);
    range_sel = 1'b0;
    for (int i = 0; i < 4; i++) begin
      clamp = clamp_tbl[i];
      scale_b(8'h45, 6'h3A);
      chk({sign_b, ofs_b}, {10'h000, (clamp < 6'h05) ? clamp : 6'h05});
    end
    clamp = 6'h3F;
    range_sel = 1'b1;
    scale_b(8'h45, 6'h3A);
    chk({seen, sign_b, ofs_b}, 16'h02C5);
    scale_b(8'h42, 6'h3C);
    chk({seen, sign_b, ofs_b}, 16'h0145);
    $display("test static scaling done");
    for (int k = 0; k < 8; k++) begin
      react_val = (k < 4) ? {2'b00, k[1:0]} : {k[1:0], 2'b00};
      host(3'h1);
      ov_dgl = {6'h00, k[0]};
      uv_dgl = {12'h000, k[1:0]};
      if (k < 4) begin
        ov_cmp = 7'h01;
      end else begin
        uv_cmp = 7'h01;
      end
      n = 0;
      while ((k < 4 ? link_a.ov_flags[0] : link_a.uv_flags[0]) !== 1'b1 && n < 1000) begin
        @(negedge clk_in);
        n++;
      end
      chk((n >= lim_tbl[k] && n <= lim_tbl[k] + 5) ? 16'h0001 : 16'h0000, 16'h0001);
      wait_cyc(2);
      chk({reg_off_a[0], rst_n_a, safe_n_a, rst_n_b, safe_n_b},
          {11'h000, k < 4, (k[1:0] == 2'h0) ? 2'b11 : (k[1:0] == 2'h1) ? 2'b10 : 2'b00,
           (k < 4) ? 2'b00 : 2'b10});
      {ov_cmp, uv_cmp} = 14'h0000;
      wait_cyc(4);
      host(3'h4);
      wait_cyc(3);
      chk({link_a.ov_flags, link_a.uv_flags, 2'b00}, 16'h0000);
      $display("test reaction case %0d done", k);
    end
    end_of_test();
  end
endmodule : rail_monitor_static_scaling_tb_top
